/* File: hdl/i2c_slave_tx_path.sv */
// I2C slave transmit data path: APB registers, holding register and SCL-clocked shifter
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module i2c_slave_tx_path (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_tx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclClk,
  output logic sdaOut,
  output logic sdaOe_n
);
  import i2c_tx_pkg::*;

  // ************************************************************
  // Core domain declarations
  // ************************************************************
  regSel_t sel;
  logic access;
  logic wrCtrl;
  logic wrStat;
  logic wrHold;
  logic rdStat;
  logic slaveTx;
  logic move;
  logic ackPulse;
  logic ninthPulse;
  logic trsRise;
  logic [1:0] toCore;
  logic ackSync;
  logic ninthSync;
  mode_t mode_q, mode_d;
  txFlags_t flags_q, flags_d;
  txFlags_t readSeen_q, readSeen_d;
  logic [7:0] holdReg_q, holdReg_d;
  logic [7:0] shiftData_q, shiftData_d;
  logic shiftFree_q, shiftFree_d;
  logic reqTog_q, reqTog_d;
  logic ackSeen_q, ackSeen_d;
  logic ninthSeen_q, ninthSeen_d;
  logic [31:0] prdata_q, prdata_d;

  // ************************************************************
  // Link domain declarations
  // ************************************************************
  logic [1:0] toLink;
  logic reqSync;
  logic slaveTxL;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic ninthTog_q, ninthTog_d;
  logic [7:0] shiftReg_q, shiftReg_d;
  logic sdaDrive_q, sdaDrive_d;
  logic ackTog_q, ackTog_d;

  // ************************************************************
  // APB decode
  // ************************************************************
  // Zero-wait slave: every access completes in its first access cycle
  always_comb begin
    sel = decodeSel(paddr);
    access = psel && penable;
    wrCtrl = access && pwrite && (sel == SEL_CTRL);
    wrStat = access && pwrite && (sel == SEL_STATUS);
    wrHold = access && pwrite && (sel == SEL_HOLD);
    rdStat = access && !pwrite && (sel == SEL_STATUS);
  end

  assign pready = 1'b1;
  assign pslverr = access && (sel == SEL_NONE);
  assign prdata = prdata_q;

  // ************************************************************
  // Crossings into the core domain
  // ************************************************************
  cdc_sync #(.W(2)) coreSync (
    .clk(core_clk),
    .rst_n(rst_n),
    .din({ackTog_q, ninthTog_q}),
    .dout(toCore)
  );

  // Edge detect works on the settled second stage only
  always_comb begin
    ackSync = toCore[1];
    ninthSync = toCore[0];
    ackPulse = ackSync != ackSeen_q;
    ninthPulse = ninthSync != ninthSeen_q;
    slaveTx = mode_q == MODE_SLAVE_TX;
    move = slaveTx && !flags_q.holdEmpty && shiftFree_q;
    trsRise = wrCtrl && pwdata[CTRL_TRS_BIT] && !mode_q.txSel;
  end

  // ************************************************************
  // Core next-state logic
  // ************************************************************
  // Clears are applied first so that a same-cycle set always wins
  always_comb begin
    mode_d = mode_q;
    flags_d = flags_q;
    readSeen_d = readSeen_q;
    holdReg_d = holdReg_q;
    shiftData_d = shiftData_q;
    shiftFree_d = shiftFree_q;
    reqTog_d = reqTog_q;
    ackSeen_d = ackSync;
    ninthSeen_d = ninthSync;
    prdata_d = prdata_q;
    // Read data is captured in the setup cycle for the access cycle
    if (psel && !penable && !pwrite) begin
      prdata_d = '0;
      unique case (decodeSel(paddr))
        SEL_CTRL: begin
          prdata_d[CTRL_MST_BIT] = mode_q.masterSel;
          prdata_d[CTRL_TRS_BIT] = mode_q.txSel;
        end
        SEL_STATUS: begin
          prdata_d[STAT_EMPTY_BIT] = flags_q.holdEmpty;
          prdata_d[STAT_END_BIT] = flags_q.txEnd;
        end
        SEL_HOLD: prdata_d[7:0] = holdReg_q;
        SEL_NONE: prdata_d = '0;
      endcase
    end
    if (wrCtrl) begin
      mode_d.masterSel = pwdata[CTRL_MST_BIT];
      mode_d.txSel = pwdata[CTRL_TRS_BIT];
    end
    // Arm from the value that the read returned, so only a flag seen as 1 may clear
    if (rdStat) begin
      readSeen_d = readSeen_q | prdata_q[STAT_EMPTY_BIT:STAT_END_BIT];
    end
    if (wrStat) begin
      if (!pwdata[STAT_END_BIT] && readSeen_q.txEnd) begin
        flags_d.txEnd = 1'b0;
        readSeen_d.txEnd = 1'b0;
      end
      if (!pwdata[STAT_EMPTY_BIT] && readSeen_q.holdEmpty) begin
        flags_d.holdEmpty = 1'b0;
        readSeen_d.holdEmpty = 1'b0;
      end
    end
    // holding write stores byte, clears both flags
    if (wrHold) begin
      holdReg_d = pwdata[7:0];
      flags_d.txEnd = 1'b0;
      flags_d.holdEmpty = 1'b0;
    end
    // shifter frees as soon as the link took its byte
    if (ackPulse) begin
      shiftFree_d = 1'b1;
    end
    // move byte, hand it over, mark holding empty
    if (move) begin
      shiftData_d = holdReg_q;
      shiftFree_d = 1'b0;
      reqTog_d = ~reqTog_q;
      flags_d.holdEmpty = 1'b1;
    end
    if (trsRise) begin
      flags_d.holdEmpty = 1'b1;
    end
    // ninth rising edge with holding empty
    if (ninthPulse && flags_q.holdEmpty) begin
      flags_d.txEnd = 1'b1;
    end
    readSeen_d = readSeen_d & flags_d; // Stale arms die with their flag
  end

  // Core registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
      flags_q <= '0;
      readSeen_q <= '0;
      holdReg_q <= HOLD_RESET;
      shiftData_q <= HOLD_RESET;
      shiftFree_q <= 1'b1;
      reqTog_q <= 1'b0;
      ackSeen_q <= 1'b0;
      ninthSeen_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      mode_q <= mode_d;
      flags_q <= flags_d;
      readSeen_q <= readSeen_d;
      holdReg_q <= holdReg_d;
      shiftData_q <= shiftData_d;
      shiftFree_q <= shiftFree_d;
      reqTog_q <= reqTog_d;
      ackSeen_q <= ackSeen_d;
      ninthSeen_q <= ninthSeen_d;
      prdata_q <= prdata_d;
    end
  end

  // ************************************************************
  // Crossings into the link domain
  // ************************************************************
  // shiftData_q is stable while a request is pending, so it needs no sync
  cdc_sync #(.W(2)) linkSync (
    .clk(sclClk),
    .rst_n(rst_n),
    .din({reqTog_q, slaveTx}),
    .dout(toLink)
  );

  always_comb begin
    reqSync = toLink[1];
    slaveTxL = toLink[0];
  end

  // ************************************************************
  // Link bit counter (SCL rising edges)
  // ************************************************************
  // Counter sits in slot 0 outside slave transmit so the next byte aligns
  always_comb begin
    bitCnt_d = FIRST_SLOT;
    ninthTog_d = ninthTog_q;
    if (slaveTxL) begin
      if (bitCnt_q == ACK_SLOT) begin
        // ninth rising edge reported to the core
        ninthTog_d = ~ninthTog_q;
      end else begin
        bitCnt_d = bitCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= FIRST_SLOT;
      ninthTog_q <= 1'b0;
    end else begin
      bitCnt_q <= bitCnt_d;
      ninthTog_q <= ninthTog_d;
    end
  end

  // ************************************************************
  // Link shifter (SCL falling edges)
  // ************************************************************
  // Loading at the slot-0 falling edge gives gapless bytes when one waits
  always_comb begin
    shiftReg_d = shiftReg_q;
    sdaDrive_d = 1'b0;
    ackTog_d = ackTog_q;
    if (bitCnt_q == FIRST_SLOT) begin
      // take next byte at the byte boundary
      if (slaveTxL && (reqSync != ackTog_q)) begin
        shiftReg_d = shiftData_q;
        ackTog_d = ~ackTog_q;
        sdaDrive_d = ~shiftData_q[7];
      end else begin
        shiftReg_d = HOLD_RESET;
      end
    end else if (bitCnt_q != ACK_SLOT) begin
      // MSB first, one bit per SCL period
      shiftReg_d = {shiftReg_q[6:0], 1'b1};
      sdaDrive_d = ~shiftReg_q[6];
    end
  end

  always_ff @(negedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg_q <= HOLD_RESET;
      sdaDrive_q <= 1'b0;
      ackTog_q <= 1'b0;
    end else begin
      shiftReg_q <= shiftReg_d;
      sdaDrive_q <= sdaDrive_d;
      ackTog_q <= ackTog_d;
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~sdaDrive_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_ackArrives;
    ackPulse && !flags_q.holdEmpty && slaveTx && !wrCtrl;
  endsequence
  sequence s_nextMove;
    shiftFree_q && move;
  endsequence

  a_end_clear_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrStat && !pwdata[STAT_END_BIT] && readSeen_q.txEnd && !ninthPulse |=> !flags_q.txEnd)
    else $error("transmit-end not cleared by zero write");
  a_end_clear_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrHold && !ninthPulse |=> !flags_q.txEnd)
    else $error("transmit-end not cleared by holding write");
  a_hold_write_store: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wrHold |=> holdReg_q == $past(pwdata[7:0]))
    else $error("holding register did not store write");
  a_move_handover: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    move |=> (reqTog_q != $past(reqTog_q)) && !shiftFree_q && shiftData_q == $past(holdReg_q))
    else $error("move did not hand byte to shifter");
  a_back_to_back: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_ackArrives |=> s_nextMove)
    else $error("waiting byte not moved after shifter freed");
  a_end_set_ninth: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ninthPulse && flags_q.holdEmpty |=> flags_q.txEnd)
    else $error("transmit-end not set on ninth edge");
  a_empty_on_move: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (move || trsRise) |=> flags_q.holdEmpty)
    else $error("holding-empty not set");
  a_mode_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !slaveTx |=> $stable(reqTog_q) && $stable(shiftData_q))
    else $error("byte handed over outside slave transmit mode");
  a_ack_release: assert property (
    @(posedge sclClk) disable iff (!rst_n)
    bitCnt_q == ACK_SLOT |-> sdaOe_n)
    else $error("data line not released in ninth period");
endmodule

/* File: hdl/i2c_tx_pkg.sv */
// Package: register map, field positions and carrier types of the slave transmit path
package i2c_tx_pkg;
  // ************************************************************
  // Register map (printed offsets are word indices)
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam logic [15:0] CTRL_IDX = 16'hf078;
  localparam logic [15:0] STATUS_IDX = 16'hf07c;
  localparam logic [15:0] HOLD_IDX = 16'hf07e;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] HOLD_ADDR = {HOLD_IDX, 2'h0};
  // ************************************************************
  // Fields, reset values and counts
  // ************************************************************
  localparam int CTRL_MST_BIT = 5;
  localparam int CTRL_TRS_BIT = 4;
  localparam int STAT_EMPTY_BIT = 7;
  localparam int STAT_END_BIT = 6;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] FIRST_SLOT = 4'h0;
  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic masterSel;
    logic txSel;
  } mode_t;
  localparam mode_t MODE_SLAVE_TX = '{masterSel: 1'b0, txSel: 1'b1};
  typedef struct packed {
    logic holdEmpty;
    logic txEnd;
  } txFlags_t;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_STATUS = 2'b10,
    SEL_HOLD = 2'b11
  } regSel_t;
  // Address decode shared by read mux, write path and error answer
  function automatic regSel_t decodeSel(input logic [ADDR_W-1:0] addr);
    regSel_t sel;
    sel = SEL_NONE;
    if (addr == CTRL_ADDR) sel = SEL_CTRL;
    if (addr == STATUS_ADDR) sel = SEL_STATUS;
    if (addr == HOLD_ADDR) sel = SEL_HOLD;
    return sel;
  endfunction
endpackage

/* File: hdl/cdc_sync.sv */
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module cdc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Both stages reset to zero so toggles start equal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

/* File: test/i2c_master_model.sv */
// Behavioural I2C master that clocks bytes out of the slave transmit path
`timescale 1ns/100ps
module i2c_master_model (
  output logic sclClk,
  input wire logic sdaOut,
  input wire logic sdaOe_n
);
  // ************************************************************
  // Wire level and clocking
  // ************************************************************
  logic sda;
  logic [7:0] rxQ[$];
  int relBad;
  // Pull-up on the wire: a released line reads high, never a stale value
  assign sda = sdaOe_n ? 1'b1 : sdaOut;
  // SCL idles high between frames
  initial begin
    sclClk = 1'b1;
    relBad = 0;
  end
  // Bare pulses let the slave's mode reach the SCL domain before a frame
  task automatic pulse(input int n);
    repeat (n) begin
      #7.5 sclClk = 1'b0;
      #7.5 sclClk = 1'b1;
    end
  endtask
  // eight bits MSB first, then a released ninth slot
  // The gap holds SCL high after the seventh clock, as a slow master may;
  // a waiting byte is handed to the shifter then, as the core clock still runs; its request crosses on the two SCL rising edges left
  task automatic frame(input int nb, input int gapNs);
    logic [7:0] b;
    b = 8'h00;
    #3.3;
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < 9; i++) begin
        #7.5 sclClk = 1'b0;
        #7.5 sclClk = 1'b1;
        if (i < 8) b = {b[6:0], sda};
        else if (sda !== 1'b1) relBad++;
        if (i == 6 && gapNs > 0) #(gapNs);
      end
      rxQ.push_back(b);
    end
  endtask
endmodule

/* File: test/i2c_slave_transmit_path_tb.sv */
// Self-checking bench for the I2C slave transmit path
`timescale 1ns/100ps
module i2c_slave_transmit_path_tb;
  import i2c_tx_pkg::*;
  // ************************************************************
  // Clock, reset and bus signals
  // ************************************************************
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, sclClk, sdaOut, sdaOe_n;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er;
  logic [7:0] b0, b1;
  int seed, fail_count, n_tests;
  i2c_slave_tx_path i_i2c_slave_tx_path (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclClk(sclClk), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
  i2c_master_model i_i2c_master_model (.sclClk(sclClk), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
  // 50 ns core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; an idle cycle follows so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h1, 32'h0);
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Drain one received byte from the master and compare it
  task automatic got(input logic [7:0] exp);
    if (i_i2c_master_model.rxQ.size() == 0) chk("rx count", 32'h1, 32'h0);
    else chk("rx byte", {24'h0, exp}, {24'h0, i_i2c_master_model.rxQ.pop_front()});
  endtask
  // Leave and re-enter slave transmit around one held byte: the request and the
  // mode then cross together on SCL edges that the bit counter does not count
  task automatic arm(input logic [7:0] b);
    apb(1'b1, CTRL_ADDR, 32'h0);
    i_i2c_master_model.pulse(3);
    apb(1'b1, CTRL_ADDR, 32'h10);
    apb(1'b1, HOLD_ADDR, {24'h0, b});
    @(posedge core_clk);
    i_i2c_master_model.pulse(2);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    seed = 72155;
    fail_count = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // reset values and an unmapped address
    apb(1'b0, HOLD_ADDR, 32'h0);
    chk("hold reset", {24'h0, HOLD_RESET}, rd);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(1'b0, 18'h00004, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, CTRL_ADDR, 32'h10);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("mode", 32'h10, rd & 32'h30);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("empty on select", 32'h80, rd & 32'h80);
    i_i2c_master_model.pulse(2);
    // random single bytes, end flag after the ninth clock
    for (int k = 0; k < 3; k++) begin
      b0 = 8'($random(seed));
      arm(b0);
      i_i2c_master_model.frame(1, $unsigned($random(seed)) % 200);
      repeat (10) @(posedge core_clk);
      got(b0);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk("end set", 32'hc0, rd & 32'hc0);
    end
    // second byte written while the first is in the shifter, sent back to back
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    arm(b0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("end clr by write", 32'h0, rd & 32'h40);
    apb(1'b1, HOLD_ADDR, {24'h0, b1});
    i_i2c_master_model.frame(2, 400);
    repeat (10) @(posedge core_clk);
    got(b0);
    got(b1);
    chk("ack released", 32'h0, i_i2c_master_model.relBad);
    // clear needs a read of 1 first, and a 0 in that bit
    apb(1'b1, STATUS_ADDR, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("end unarmed", 32'h40, rd & 32'h40);
    apb(1'b1, STATUS_ADDR, 32'h40);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("end write 1", 32'h40, rd & 32'h40);
    apb(1'b1, STATUS_ADDR, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("end cleared", 32'h0, rd & 32'h40);
    // read back in receive mode, where nothing moves out
    apb(1'b1, CTRL_ADDR, 32'h0);
    for (int k = 0; k < 3; k++) begin
      b0 = 8'($random(seed));
      apb(1'b1, HOLD_ADDR, {24'h0, b0});
      apb(1'b0, HOLD_ADDR, 32'h0);
      chk("hold rw", {24'h0, b0}, rd);
    end
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("no move in rx", 32'h0, rd & 32'h80);
    conclude();
  end
endmodule
